// file: resv_fwd_pkg.sv
package resv_fwd_pkg;

    // ------------------------------------------------------------
    // Register indices; the byte address is four times the index.
    // ------------------------------------------------------------
    localparam int         IDX_W               = 7;
    localparam logic [6:0] PORT_FWD_CTL_IDX    = 7'h21;
    localparam logic [6:0] RESV_MCAST_CTL_IDX  = 7'h2F;
    localparam logic [6:0] UCAST_MASK_IDX      = 7'h32;
    localparam logic [6:0] SWITCH_MODE_IDX     = 7'h40;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LEARN_BIT        = 7;
    localparam int RANGE4_BIT       = 4;
    localparam int RANGE3_BIT       = 3;
    localparam int RANGE2_BIT       = 2;
    localparam int RANGE1_BIT       = 1;
    localparam int RANGE0_BIT       = 0;
    localparam int UCAST_FWD_EN_BIT = 6;
    localparam int UNMANAGED_BIT    = 0;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int         NUM_PORTS          = 9;
    localparam int         RESV_CTL_W         = 8;
    localparam logic [7:0] RESV_MCAST_CTL_RST = 8'h02;
    localparam logic       UCAST_FWD_EN_RST   = 1'b0;
    localparam logic [8:0] UCAST_MASK_RST     = 9'h000;
    localparam logic [8:0] ALL_PORTS          = 9'h1FF;
    localparam logic       UNMANAGED_RST      = 1'b1;

    // ------------------------------------------------------------
    // Reserved multicast group and its sub-ranges
    // ------------------------------------------------------------
    localparam logic [39:0] RESV_PREFIX = 40'h0180C20000;
    localparam logic [7:0]  R0_ADDR     = 8'h00;
    localparam logic [7:0]  R1_LO       = 8'h02;
    localparam logic [7:0]  R1_HI       = 8'h0F;
    localparam logic [7:0]  R2_ADDR     = 8'h10;
    localparam logic [7:0]  R3_LO       = 8'h11;
    localparam logic [7:0]  R3_HI       = 8'h1F;
    localparam logic [7:0]  R4_LO       = 8'h20;
    localparam logic [7:0]  R4_HI       = 8'h2F;

    typedef struct packed {
        logic        valid;
        logic [47:0] dest_mac;
        logic        ucast_miss;
    } frame_req_t;

    typedef struct packed {
        logic                 valid;
        logic                 drop;
        logic                 learn_ok;
        logic                 flood;
        logic [NUM_PORTS-1:0] port_mask;
    } fwd_decision_t;

endpackage

// file: resv_fwd_ctrl.sv
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module resv_fwd_ctrl
(
    input  wire logic                       clock_i,      // Switch core clock, 20 MHz.
    input  wire logic                       rst_n_i,      // Synchronous reset, active low.
    input  wire logic                       hsel_i,       // AHB slave select.
    input  wire logic [31:0]                haddr_i,      // AHB address.
    input  wire logic [1:0]                 htrans_i,     // AHB transfer type.
    input  wire logic                       hwrite_i,     // AHB write flag.
    input  wire logic [2:0]                 hsize_i,      // AHB size.
    input  wire logic [31:0]                hwdata_i,     // AHB write data.
    input  wire logic                       hready_i,     // AHB bus ready.
    output logic [31:0]                     hrdata_o,     // AHB read data.
    output logic                            hreadyout_o,  // AHB slave ready.
    output logic                            hresp_o,      // AHB response, always OKAY.
    input  wire resv_fwd_pkg::frame_req_t   frame_req_i,  // Frame lookup result.
    output resv_fwd_pkg::fwd_decision_t     decision_o    // Forwarding decision.
);
    import resv_fwd_pkg::*;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [RESV_CTL_W-1:0] resv_ctl_r;
    logic                  ucast_fwd_en_r;
    logic [NUM_PORTS-1:0]  ucast_mask_r;
    logic                  unmanaged_r;
    logic                  wr_pend_r;
    logic [IDX_W-1:0]      wr_idx_r;
    logic [31:0]           hrdata_r;
    fwd_decision_t         decision_r;

    function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo,
                                      input logic [7:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire              access_w   = hsel_i && htrans_i[1] && hready_i;
    wire [IDX_W-1:0]  addr_idx_w = haddr_i[IDX_W+1:2];
    wire              rd_req_w   = access_w && !hwrite_i;
    wire              wr_req_w   = access_w && hwrite_i;

    wire wr_resv_w  = wr_pend_r && (wr_idx_r == RESV_MCAST_CTL_IDX);
    wire wr_pfc_w   = wr_pend_r && (wr_idx_r == PORT_FWD_CTL_IDX);
    wire wr_mask_w  = wr_pend_r && (wr_idx_r == UCAST_MASK_IDX);
    wire wr_mode_w  = wr_pend_r && (wr_idx_r == SWITCH_MODE_IDX);

    // Unmapped indices read as zero; the upper mask bits are reserved zero.
    wire [31:0] rd_mux_w =
        (addr_idx_w == RESV_MCAST_CTL_IDX) ? {24'h000000, resv_ctl_r} :
        (addr_idx_w == PORT_FWD_CTL_IDX)   ? (32'(ucast_fwd_en_r) << UCAST_FWD_EN_BIT) :
        (addr_idx_w == UCAST_MASK_IDX)     ? {23'h000000, ucast_mask_r} :
        (addr_idx_w == SWITCH_MODE_IDX)    ? (32'(unmanaged_r) << UNMANAGED_BIT) :
        32'h00000000;

    // ------------------------------------------------------------
    // AHB slave: zero wait states, write lands at the end of its data phase.
    // ------------------------------------------------------------
    // A read whose address phase meets the data phase of a write to the
    // same register returns the old value; software that needs the new one
    // leaves a cycle between them. This saves a bypass path on read data.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= '0;
            hrdata_r  <= 32'h00000000;
        end
        else
        begin
            if (hready_i)
            begin
                wr_pend_r <= wr_req_w;
                wr_idx_r  <= addr_idx_w;
            end
            if (rd_req_w)
                hrdata_r <= rd_mux_w;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            resv_ctl_r     <= RESV_MCAST_CTL_RST;
            ucast_fwd_en_r <= UCAST_FWD_EN_RST;
            ucast_mask_r   <= UCAST_MASK_RST;
            unmanaged_r    <= UNMANAGED_RST;
        end
        else
        begin
            if (wr_resv_w)
                resv_ctl_r <= hwdata_i[RESV_CTL_W-1:0];
            if (wr_pfc_w)
                ucast_fwd_en_r <= hwdata_i[UCAST_FWD_EN_BIT];
            if (wr_mask_w)
                ucast_mask_r <= hwdata_i[NUM_PORTS-1:0];
            if (wr_mode_w)
                unmanaged_r <= hwdata_i[UNMANAGED_BIT];
        end
    end

    assign hrdata_o    = hrdata_r;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    // ------------------------------------------------------------
    // Reserved multicast classification
    // ------------------------------------------------------------
    wire [7:0] low_w   = frame_req_i.dest_mac[7:0];
    wire       resv_w  = (frame_req_i.dest_mac[47:8] == RESV_PREFIX);
    wire       hit0_w  = resv_w && (low_w == R0_ADDR);
    wire       hit1_w  = resv_w && in_range(low_w, R1_LO, R1_HI);
    wire       hit2_w  = resv_w && (low_w == R2_ADDR);
    wire       hit3_w  = resv_w && in_range(low_w, R3_LO, R3_HI);
    wire       hit4_w  = resv_w && in_range(low_w, R4_LO, R4_HI);

    // The drop bits only matter in unmanaged mode; a managed switch leaves
    // these frames to the rest of the forwarding rules.
    wire resv_drop_w = unmanaged_r && (
        (hit4_w && resv_ctl_r[RANGE4_BIT]) ||
        (hit3_w && resv_ctl_r[RANGE3_BIT]) ||
        (hit2_w && resv_ctl_r[RANGE2_BIT]) ||
        (hit1_w && resv_ctl_r[RANGE1_BIT]) ||
        (hit0_w && resv_ctl_r[RANGE0_BIT]));

    // Learning looks at the whole group, not only the droppable ranges, so
    // addresses 01 and 30 to FF of the group are held back as well.
    wire learn_ok_w = !resv_w || resv_ctl_r[LEARN_BIT];

    // ------------------------------------------------------------
    // Unknown-unicast forwarding
    // ------------------------------------------------------------
    wire       miss_w      = frame_req_i.ucast_miss;
    wire       mask_fwd_w  = miss_w && ucast_fwd_en_r;
    wire       flood_w     = miss_w && !ucast_fwd_en_r;
    wire [NUM_PORTS-1:0] port_mask_w =
        mask_fwd_w ? ucast_mask_r :
        flood_w    ? ALL_PORTS    :
        {NUM_PORTS{1'b0}};
    wire       mask_drop_w = mask_fwd_w && (ucast_mask_r == '0);

    // Every field is gated by the request so the engine sees all zeros
    // between frames and cannot act twice on one stale decision.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            decision_r <= '0;
        else
        begin
            decision_r.valid     <= frame_req_i.valid;
            decision_r.drop      <= frame_req_i.valid && (resv_drop_w || mask_drop_w);
            decision_r.learn_ok  <= frame_req_i.valid && learn_ok_w;
            decision_r.flood     <= frame_req_i.valid && flood_w;
            decision_r.port_mask <= frame_req_i.valid ? port_mask_w : {NUM_PORTS{1'b0}};
        end
    end

    assign decision_o = decision_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // All checks run on the core clock; all but reset_value_a are masked while reset is low.
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    wire mgd_w = unmanaged_r;

    learn_block_a: assert property (
        frame_req_i.valid && resv_w && !resv_ctl_r[LEARN_BIT]
        |=> decision_o.valid && !decision_o.learn_ok)
        else $error("Source learned from reserved multicast frame.");

    learn_allow_a: assert property (
        frame_req_i.valid && resv_ctl_r[LEARN_BIT]
        |=> decision_o.learn_ok)
        else $error("Learning refused with learning bit set.");

    // Each range check allows for a miss that an empty mask drops on the
    // same frame.
    range_four_a: assert property (
        frame_req_i.valid && mgd_w && resv_w
        && low_w >= R4_LO && low_w <= R4_HI
        |=> decision_o.drop == ($past(resv_ctl_r[RANGE4_BIT]) || $past(mask_drop_w)))
        else $error("Range four drop mismatch.");

    range_three_a: assert property (
        frame_req_i.valid && mgd_w && resv_w
        && low_w >= R3_LO && low_w <= R3_HI
        |=> decision_o.drop == ($past(resv_ctl_r[RANGE3_BIT]) || $past(mask_drop_w)))
        else $error("Range three drop mismatch.");

    range_two_a: assert property (
        frame_req_i.valid && mgd_w && resv_w && low_w == R2_ADDR
        |=> decision_o.drop == ($past(resv_ctl_r[RANGE2_BIT]) || $past(mask_drop_w)))
        else $error("Range two drop mismatch.");

    range_one_a: assert property (
        frame_req_i.valid && mgd_w && resv_w
        && low_w >= R1_LO && low_w <= R1_HI
        |=> decision_o.drop == ($past(resv_ctl_r[RANGE1_BIT]) || $past(mask_drop_w)))
        else $error("Range one drop mismatch.");

    range_zero_a: assert property (
        frame_req_i.valid && mgd_w && resv_w && low_w == R0_ADDR
        |=> decision_o.drop == ($past(resv_ctl_r[RANGE0_BIT]) || $past(mask_drop_w)))
        else $error("Range zero drop mismatch.");

    mask_read_a: assert property (
        rd_req_w && addr_idx_w == UCAST_MASK_IDX
        |=> hrdata_o[31:9] == 23'h000000 && hrdata_o[8:0] == $past(ucast_mask_r))
        else $error("Mask read value wrong.");

    mask_fwd_a: assert property (
        frame_req_i.valid && miss_w && ucast_fwd_en_r
        |=> decision_o.port_mask == $past(ucast_mask_r) && !decision_o.flood)
        else $error("Unicast miss not sent to masked ports.");

    mask_empty_a: assert property (
        frame_req_i.valid && miss_w && ucast_fwd_en_r && ucast_mask_r == 9'h000
        |=> decision_o.drop)
        else $error("Miss with empty mask not dropped.");

    flood_miss_a: assert property (
        frame_req_i.valid && miss_w && !ucast_fwd_en_r
        |=> decision_o.flood && decision_o.port_mask == 9'h1FF)
        else $error("Unicast miss not flooded.");

    managed_pass_a: assert property (
        frame_req_i.valid && !unmanaged_r && !miss_w
        |=> !decision_o.drop)
        else $error("Reserved frame dropped outside unmanaged mode.");

    // ------------------------------------------------------------
    // Register file assertions
    // ------------------------------------------------------------
    // A write lands at the edge that ends its data phase, so each register
    // must show the data-phase word one edge after its write strobe.
    resv_write_a: assert property (
        wr_resv_w
        |=> resv_ctl_r == $past(hwdata_i[RESV_CTL_W-1:0]))
        else $error("Reserved multicast control write lost.");

    enable_write_a: assert property (
        wr_pfc_w
        |=> ucast_fwd_en_r == $past(hwdata_i[UCAST_FWD_EN_BIT]))
        else $error("Mask forwarding enable write lost.");

    mask_write_a: assert property (
        wr_mask_w
        |=> ucast_mask_r == $past(hwdata_i[NUM_PORTS-1:0]))
        else $error("Unknown unicast mask write lost.");

    mode_write_a: assert property (
        wr_mode_w
        |=> unmanaged_r == $past(hwdata_i[UNMANAGED_BIT]))
        else $error("Switch mode write lost.");

    resv_read_a: assert property (
        rd_req_w && addr_idx_w == RESV_MCAST_CTL_IDX
        |=> hrdata_o == {24'h000000, $past(resv_ctl_r)})
        else $error("Reserved multicast control read value wrong.");

    enable_read_a: assert property (
        rd_req_w && addr_idx_w == PORT_FWD_CTL_IDX
        |=> hrdata_o[UCAST_FWD_EN_BIT] == $past(ucast_fwd_en_r))
        else $error("Mask forwarding enable read value wrong.");

    // The reset check must also run while reset is low, so it overrides the
    // default disable condition.
    reset_value_a: assert property (disable iff (1'b0)
        !rst_n_i
        |=> resv_ctl_r == RESV_MCAST_CTL_RST && ucast_mask_r == UCAST_MASK_RST
            && ucast_fwd_en_r == UCAST_FWD_EN_RST && unmanaged_r == UNMANAGED_RST)
        else $error("Register not at its reset value.");

    // ------------------------------------------------------------
    // Decision assertions
    // ------------------------------------------------------------
    decision_idle_a: assert property (
        !frame_req_i.valid
        |=> decision_o == '0)
        else $error("Decision shown without a frame request.");

    frame_answer_a: assert property (
        frame_req_i.valid
        |=> decision_o.valid)
        else $error("Frame request without a decision.");

    learn_normal_a: assert property (
        frame_req_i.valid && !resv_w
        |=> decision_o.learn_ok)
        else $error("Learning refused for an ordinary destination.");

    hit_mask_a: assert property (
        frame_req_i.valid && !miss_w
        |=> decision_o.port_mask == 9'h000 && !decision_o.flood)
        else $error("Port mask given for a frame that did not miss.");

    mask_keep_a: assert property (
        frame_req_i.valid && miss_w && ucast_fwd_en_r && ucast_mask_r != 9'h000
        && !resv_drop_w
        |=> !decision_o.drop)
        else $error("Miss with a non-empty mask dropped.");

    flood_keep_a: assert property (
        frame_req_i.valid && miss_w && !ucast_fwd_en_r && !resv_drop_w
        |=> !decision_o.drop)
        else $error("Flooded miss dropped.");

    plain_pass_a: assert property (
        frame_req_i.valid && !resv_w && !miss_w
        |=> !decision_o.drop)
        else $error("Frame outside the reserved group dropped.");

    bits_clear_a: assert property (
        frame_req_i.valid && resv_w && !miss_w
        && resv_ctl_r[RANGE4_BIT:RANGE0_BIT] == 5'h00
        |=> !decision_o.drop)
        else $error("Reserved frame dropped with every drop bit clear.");

    // Address 01 of the group lies between range zero and range one and is
    // never dropped by these bits.
    gap_pass_a: assert property (
        frame_req_i.valid && resv_w && low_w == 8'h01 && !miss_w
        |=> !decision_o.drop)
        else $error("Group address 01 dropped.");

endmodule

// file: fwd_engine_model.sv
`timescale 1ns/100ps
module fwd_engine_model
(
    input  wire logic                          clock_i,     // Core clock.
    input  wire resv_fwd_pkg::fwd_decision_t   decision_i,  // Decision from the block.
    output resv_fwd_pkg::frame_req_t           frame_req_o  // Lookup result to the block.
);
    import resv_fwd_pkg::*;

    fwd_decision_t seen;  // Decision taken one edge after the request.

    initial frame_req_o = '0;

    // Between frames the address lines carry the inverse of the last one, so a
    // block that samples a stale request cannot pass by luck.
    task automatic send(input logic [47:0] mac, input logic miss);
        @(posedge clock_i);
        frame_req_o <= '{valid: 1'b1, dest_mac: mac, ucast_miss: miss};
        @(posedge clock_i);
        frame_req_o <= '{valid: 1'b0, dest_mac: ~mac, ucast_miss: ~miss};
        @(negedge clock_i);
        seen = decision_i;
    endtask
endmodule

// file: testbench.sv
`timescale 1ns/100ps
module testbench;
    import resv_fwd_pkg::*;

    typedef struct packed {
        logic       md;
        logic [7:0] ctl;
        logic       en;
        logic [8:0] msk;
        logic       rs;
        logic [7:0] lo;
        logic       ms;
        logic       dr;
        logic       ln;
        logic       fl;
        logic [8:0] pm;
    } row_t;

    logic          clock_i = 1'b0;
    logic          rst_n_i = 1'b0;
    logic [31:0]   haddr_i = 32'h0;
    logic [1:0]    htrans_i = 2'h0;
    logic          hwrite_i = 1'b0;
    logic [31:0]   hwdata_i = 32'h0;
    logic [31:0]   hrdata_o;
    logic          hreadyout_o;
    logic          hresp_o;
    frame_req_t    frame_req_i;
    fwd_decision_t decision_o;
    fwd_decision_t exp_d;
    logic [31:0]   rd;
    int            failures = 0;
    int            samples_checked = 0;

    // ------------------------------------------------------------
    // Ordinary cases: configuration, frame, expected decision
    // ------------------------------------------------------------
    row_t rows [23] = '{
        '{1, 8'h02, 0, 9'h000, 1, 8'h00, 0, 0, 0, 0, 9'h000},
        '{1, 8'h01, 0, 9'h000, 1, 8'h00, 0, 1, 0, 0, 9'h000},
        '{1, 8'h1F, 0, 9'h000, 1, 8'h01, 0, 0, 0, 0, 9'h000},
        '{1, 8'h02, 0, 9'h000, 1, 8'h02, 0, 1, 0, 0, 9'h000},
        '{1, 8'h02, 0, 9'h000, 1, 8'h0F, 0, 1, 0, 0, 9'h000},
        '{1, 8'h1D, 0, 9'h000, 1, 8'h0F, 0, 0, 0, 0, 9'h000},
        '{1, 8'h04, 0, 9'h000, 1, 8'h10, 0, 1, 0, 0, 9'h000},
        '{1, 8'h1B, 0, 9'h000, 1, 8'h10, 0, 0, 0, 0, 9'h000},
        '{1, 8'h08, 0, 9'h000, 1, 8'h11, 0, 1, 0, 0, 9'h000},
        '{1, 8'h08, 0, 9'h000, 1, 8'h1F, 0, 1, 0, 0, 9'h000},
        '{1, 8'h17, 0, 9'h000, 1, 8'h1F, 0, 0, 0, 0, 9'h000},
        '{1, 8'h10, 0, 9'h000, 1, 8'h20, 0, 1, 0, 0, 9'h000},
        '{1, 8'h10, 0, 9'h000, 1, 8'h2F, 0, 1, 0, 0, 9'h000},
        '{1, 8'h1F, 0, 9'h000, 1, 8'h30, 0, 0, 0, 0, 9'h000},
        '{1, 8'h9F, 0, 9'h000, 1, 8'h02, 0, 1, 1, 0, 9'h000},
        '{0, 8'h1F, 0, 9'h000, 1, 8'h00, 0, 0, 0, 0, 9'h000},
        '{1, 8'h1F, 0, 9'h000, 0, 8'h00, 0, 0, 1, 0, 9'h000},
        '{1, 8'h00, 0, 9'h000, 0, 8'h55, 1, 0, 1, 1, 9'h1FF},
        '{1, 8'h00, 1, 9'h101, 0, 8'h55, 1, 0, 1, 0, 9'h101},
        '{1, 8'h00, 1, 9'h0FE, 0, 8'h55, 1, 0, 1, 0, 9'h0FE},
        '{1, 8'h00, 1, 9'h000, 0, 8'h55, 1, 1, 1, 0, 9'h000},
        '{1, 8'h00, 1, 9'h0FE, 1, 8'h20, 0, 0, 0, 0, 9'h000},
        '{0, 8'h00, 1, 9'h100, 0, 8'h55, 1, 0, 1, 0, 9'h100}
    };

    initial forever #25 clock_i = ~clock_i;

    resv_fwd_ctrl uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .hsel_i(1'b1), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .frame_req_i(frame_req_i), .decision_o(decision_o));

    fwd_engine_model partner (.clock_i(clock_i), .decision_i(decision_o),
        .frame_req_o(frame_req_i));

    task automatic wait_rdy;
        do
            @(posedge clock_i);
        while (hreadyout_o !== 1'b1);
    endtask

    task automatic ahb(input logic [6:0] idx, input logic wr, input logic [31:0] wd,
                       output logic [31:0] rdat);
        @(posedge clock_i);
        haddr_i <= {23'h0, idx, 2'h0};
        htrans_i <= 2'h2;
        hwrite_i <= wr;
        wait_rdy();
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        wait_rdy();
        rdat = hrdata_o;
    endtask

    task automatic chk_reg(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk_dec(input string nm, input fwd_decision_t exp, input fwd_decision_t got);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic end_sim;
        if (failures == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #(3000 * 50);
        failures++;
        end_sim();
    end

    initial
    begin
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        foreach (rows[i])
        begin
            ahb(SWITCH_MODE_IDX, 1'b1, {31'h0, rows[i].md}, rd);
            ahb(RESV_MCAST_CTL_IDX, 1'b1, {24'h0, rows[i].ctl}, rd);
            ahb(PORT_FWD_CTL_IDX, 1'b1, {25'h0, rows[i].en, 6'h00}, rd);
            ahb(UCAST_MASK_IDX, 1'b1, {23'h0, rows[i].msk}, rd);
            partner.send(rows[i].rs ? {RESV_PREFIX, rows[i].lo} : {40'h0011223344, rows[i].lo},
                         rows[i].ms);
            exp_d = {1'b1, rows[i].dr, rows[i].ln, rows[i].fl, rows[i].pm};
            chk_dec("decision", exp_d, partner.seen);
        end
        // A second reset in mid-run must bring every register back to its default.
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        chk_dec("reset decision", '0, decision_o);
        rst_n_i <= 1'b1;
        ahb(RESV_MCAST_CTL_IDX, 1'b0, 32'h0, rd);
        chk_reg("mcast ctl reset", 32'h0000_0002, rd);
        ahb(PORT_FWD_CTL_IDX, 1'b0, 32'h0, rd);
        chk_reg("fwd enable reset", 32'h0, rd);
        ahb(UCAST_MASK_IDX, 1'b0, 32'h0, rd);
        chk_reg("mask reset", 32'h0, rd);
        ahb(SWITCH_MODE_IDX, 1'b0, 32'h0, rd);
        chk_reg("mode reset", 32'h1, rd);
        chk_reg("hresp", 32'h0, {31'h0, hresp_o});
        ahb(UCAST_MASK_IDX, 1'b1, 32'hFFFF_FFFF, rd);
        ahb(UCAST_MASK_IDX, 1'b0, 32'h0, rd);
        chk_reg("mask width", 32'h0000_01FF, rd);
        ahb(7'h7F, 1'b1, 32'hFFFF_FFFF, rd);
        ahb(7'h7F, 1'b0, 32'h0, rd);
        chk_reg("unmapped", 32'h0, rd);
        end_sim();
    end
endmodule
